// File: logic/pod_consts.svh
`ifndef POD_CONSTS_SVH
`define POD_CONSTS_SVH

// Register offsets
`define POD_UPDATE_ADDR    16'h0005
`define POD_CONTROL_ADDR   16'h0200
`define POD_STATUS_ADDR    16'h0201
`define POD_DIVIDER_BASE   16'h0210
`define POD_DRIVER_BASE    16'h0220

// Field positions
`define POD_UPDATE_BIT     0
`define POD_CAL_BIT        1
`define POD_SYNC_BIT       2
`define POD_PD_BIT         5

// Reset values
`define POD_CONTROL_RST    8'h00
`define POD_DIVIDER_RST    8'h00
`define POD_DRIVER_RST     6'h00

// Sizes
`define POD_GROUPS         4
`define POD_DRIVERS        12

`endif

// File: logic/pod_pkg.sv
package pod_pkg;

  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_HSTL     = 3'h1,
    MODE_CMOS_PN  = 3'h4,
    MODE_CMOS_P   = 3'h5,
    MODE_CMOS_N   = 3'h6
  } pod_mode_type;

  typedef struct packed {
    logic       powerDown;
    logic [1:0] polarity;
    logic [2:0] mode;
  } pod_driver_type;

  typedef struct packed {
    logic        wrEn;
    logic [15:0] addr;
    logic [7:0]  wrData;
  } pod_write_type;

  typedef enum {
    SYNC_RUN,
    SYNC_HOLD,
    SYNC_WAIT
  } pod_sync_type;

endpackage : pod_pkg

// File: logic/pod_channel_divider.sv
`timescale 1ns/100ps
`include "pod_consts.svh"
module pod_channel_divider #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             hold,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] ratio,
  output logic                  divOut
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH:0]   half;

  // Counts 0..ratio, so the period is ratio+1 ticks
  assign next_count = (count >= ratio) ? '0 : count + 1'b1;
  // Odd periods round the high time up; tick granularity limits accuracy
  assign half = ({1'b0, ratio} + (WIDTH+1)'(2)) >> 1;

  always_ff @(posedge core_clk) begin
    if (!rst_n || hold) begin
      count <= '0;
    end else if (tick) begin
      count <= next_count;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || hold) begin
      divOut <= 1'b0;
    end else if (ratio == '0) begin
      divOut <= tick;
    end else if (tick) begin
      divOut <= ({1'b0, next_count} < half);
    end
  end

endmodule : pod_channel_divider

// File: logic/pod_distribution.sv
`timescale 1ns/100ps
`include "pod_consts.svh"
module pod_distribution
  import pod_pkg::*;
#(
  parameter int DRIVERS = `POD_DRIVERS,
  parameter int GROUPS  = `POD_GROUPS
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire pod_write_type       regWrite,
  input  wire logic [15:0]         rdAddr,
  input  wire logic                vcoPostDividerTick,
  input  wire logic                loopLocked,
  input  wire logic                calDone,
  output logic [7:0]               rdData,
  output logic [DRIVERS-1:0]       outputPositivePin,
  output logic [DRIVERS-1:0]       outputNegativePin,
  output logic [GROUPS-1:0]        groupDividerDown,
  output logic                     manualCalibrate
);

  ////////////////////////////////////////////////////////////////////////
  // Register file: shadow copies written by software, active copies used

  logic [7:0]     shadowControl;
  logic [7:0]     activeControl;
  logic [7:0]     shadowDivider [GROUPS];
  logic [7:0]     activeDivider [GROUPS];
  pod_driver_type shadowDriver  [DRIVERS];
  pod_driver_type activeDriver  [DRIVERS];
  logic           updatePulse;
  logic           syncPending;
  logic           holdDividers;
  pod_sync_type   syncState;

  // Group of each driver: A 0-1, B 2-4, C 5-7, D 8-11
  function automatic logic [1:0] groupOf(input int idx);
    if (idx < 2) begin
      return 2'h0;
    end else if (idx < 5) begin
      return 2'h1;
    end else if (idx < 8) begin
      return 2'h2;
    end else begin
      return 2'h3;
    end
  endfunction : groupOf

  // Self-clearing strobe: one pulse per write of a one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      updatePulse <= 1'b0;
    end else begin
      updatePulse <= regWrite.wrEn && regWrite.addr == `POD_UPDATE_ADDR
                     && regWrite.wrData[`POD_UPDATE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shadowControl <= `POD_CONTROL_RST;
    end else if (regWrite.wrEn && regWrite.addr == `POD_CONTROL_ADDR) begin
      shadowControl <= regWrite.wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      activeControl <= `POD_CONTROL_RST;
    end else if (updatePulse) begin
      activeControl <= shadowControl;
    end
  end

  for (genvar g = 0; g < GROUPS; g++) begin : gDivReg
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        shadowDivider[g] <= `POD_DIVIDER_RST;
      end else if (regWrite.wrEn
                   && regWrite.addr == `POD_DIVIDER_BASE + 16'(g)) begin
        shadowDivider[g] <= regWrite.wrData;
      end
    end
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        activeDivider[g] <= `POD_DIVIDER_RST;
      end else if (updatePulse) begin
        activeDivider[g] <= shadowDivider[g];
      end
    end
  end

  for (genvar d = 0; d < DRIVERS; d++) begin : gDrvReg
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        shadowDriver[d] <= `POD_DRIVER_RST;
      end else if (regWrite.wrEn
                   && regWrite.addr == `POD_DRIVER_BASE + 16'(d)) begin
        shadowDriver[d] <= regWrite.wrData[5:0];
      end
    end
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        activeDriver[d] <= `POD_DRIVER_RST;
      end else if (updatePulse) begin
        activeDriver[d] <= shadowDriver[d];
      end
    end
  end

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (rdAddr == `POD_UPDATE_ADDR) begin
      rdData <= {7'h00, updatePulse};
    end else if (rdAddr == `POD_CONTROL_ADDR) begin
      rdData <= shadowControl;
    end else if (rdAddr == `POD_STATUS_ADDR) begin
      rdData <= {4'h0, holdDividers, syncPending, calDone, loopLocked};
    end else if (rdAddr >= `POD_DIVIDER_BASE
                 && rdAddr < `POD_DIVIDER_BASE + 16'(GROUPS)) begin
      rdData <= shadowDivider[2'(rdAddr - `POD_DIVIDER_BASE)];
    end else if (rdAddr >= `POD_DRIVER_BASE
                 && rdAddr < `POD_DRIVER_BASE + 16'(DRIVERS)) begin
      rdData <= {2'h0, shadowDriver[4'(rdAddr - `POD_DRIVER_BASE)]};
    end else begin
      rdData <= 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      manualCalibrate <= 1'b0;
    end else begin
      manualCalibrate <= activeControl[`POD_CAL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync: pulse high holds dividers; release on fall once qualified

  logic syncLevel;
  logic qualified;
  assign syncLevel = activeControl[`POD_SYNC_BIT];
  assign qualified = loopLocked && calDone;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      syncState <= SYNC_RUN;
    end else begin
      case (syncState)
        SYNC_RUN: begin
          if (syncLevel) begin
            syncState <= SYNC_HOLD;
          end
        end
        SYNC_HOLD: begin
          if (!syncLevel && qualified) begin
            syncState <= SYNC_RUN;
          end else if (!syncLevel) begin
            syncState <= SYNC_WAIT;
          end
        end
        SYNC_WAIT: begin
          if (syncLevel) begin
            syncState <= SYNC_HOLD;
          end else if (qualified) begin
            syncState <= SYNC_RUN;
          end
        end
        default: syncState <= SYNC_RUN;
      endcase
    end
  end

  // Hold and pending flags derived as next-state so release is immediate
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      holdDividers <= 1'b0;
      syncPending  <= 1'b0;
    end else begin
      holdDividers <= syncLevel || (syncState != SYNC_RUN && !qualified)
                      || (syncState == SYNC_WAIT && !qualified);
      syncPending  <= !syncLevel && syncState != SYNC_RUN && !qualified;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel dividers and drivers

  logic [DRIVERS-1:0] driverOn;
  logic [GROUPS-1:0]  groupAnyOn;
  logic [GROUPS-1:0]  divClk;

  for (genvar d = 0; d < DRIVERS; d++) begin : gDrvOn
    // Undefined mode codes leave the driver off as a safe choice
    assign driverOn[d] = !activeDriver[d].powerDown
      && (activeDriver[d].mode == MODE_HSTL
          || activeDriver[d].mode == MODE_CMOS_PN
          || activeDriver[d].mode == MODE_CMOS_P
          || activeDriver[d].mode == MODE_CMOS_N);
  end

  for (genvar g = 0; g < GROUPS; g++) begin : gGroup
    logic [DRIVERS-1:0] member;
    for (genvar d = 0; d < DRIVERS; d++) begin : gMember
      assign member[d] = (groupOf(d) == 2'(g)) && driverOn[d];
    end
    assign groupAnyOn[g] = |member;

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        groupDividerDown[g] <= 1'b1;
      end else begin
        groupDividerDown[g] <= !groupAnyOn[g];
      end
    end

    // One shared hold releases the dividers of all groups with a driver on on the same edge
    pod_channel_divider #(.WIDTH(8)) uDiv (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .hold     (holdDividers || !groupAnyOn[g]),
      .tick     (vcoPostDividerTick && !holdDividers),
      .ratio    (activeDivider[g]),
      .divOut   (divClk[g])
    );
  end

  for (genvar d = 0; d < DRIVERS; d++) begin : gDrvOut
    logic clkIn;
    logic invP;
    logic invN;
    assign clkIn = divClk[groupOf(d)];
    assign invP  = activeDriver[d].polarity[1];
    // In MODE_CMOS_PN and MODE_CMOS_N the negative pin inverts when the low polarity bit is clear
    assign invN  = ~activeDriver[d].polarity[0];

    always_ff @(posedge core_clk) begin
      if (!rst_n || !driverOn[d]) begin
        outputPositivePin[d] <= 1'b0;
        outputNegativePin[d] <= 1'b0;
      end else begin
        case (activeDriver[d].mode)
          MODE_HSTL: begin
            outputPositivePin[d] <= clkIn;
            outputNegativePin[d] <= ~clkIn;
          end
          MODE_CMOS_PN: begin
            outputPositivePin[d] <= clkIn ^ invP;
            outputNegativePin[d] <= clkIn ^ invN;
          end
          MODE_CMOS_P: begin
            outputPositivePin[d] <= clkIn ^ invP;
            outputNegativePin[d] <= 1'b0;
          end
          MODE_CMOS_N: begin
            outputPositivePin[d] <= 1'b0;
            outputNegativePin[d] <= clkIn ^ invN;
          end
          default: begin
            outputPositivePin[d] <= 1'b0;
            outputNegativePin[d] <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : pod_distribution

// File: testbench/pod_loop_model.sv
`timescale 1ns/100ps
module pod_loop_model #(
  parameter int TICK_DIV = 2
) (
  input  wire logic core_clk,
  input  wire logic lockEn,
  input  wire logic calEn,
  output logic      tick = 1'b0,
  output logic      locked = 1'b0,
  output logic      calOk = 1'b0
);
  int cnt = 0;
  // The dividers count these ticks, never core_clk itself
  always @(posedge core_clk) begin
    cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    tick <= (cnt == TICK_DIV - 1);
  end
  // Flags lag the requests by a cycle, as a real status path would
  always @(posedge core_clk) begin
    locked <= lockEn;
    calOk <= calEn;
  end
endmodule : pod_loop_model

// File: testbench/pod_distribution_asserts.sv
`timescale 1ns/100ps
module pod_distribution_chk
  import pod_pkg::*;
#(
  parameter int DRIVERS = 12,
  parameter int GROUPS  = 4
) (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire pod_write_type      regWrite,
  input wire logic [15:0]        rdAddr,
  input wire logic [7:0]         rdData,
  input wire logic               loopLocked,
  input wire logic               calDone,
  input wire logic [DRIVERS-1:0] outputPositivePin,
  input wire logic [DRIVERS-1:0] outputNegativePin,
  input wire logic [GROUPS-1:0]  groupDividerDown,
  input wire logic               manualCalibrate
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire updW = regWrite.wrEn && regWrite.addr == 16'h0005
              && regWrite.wrData[0];
  sequence updRd;
    updW ##1 rdAddr == 16'h0005;
  endsequence
  sequence quietRd;
    !updW ##1 rdAddr == 16'h0005;
  endsequence
  a_update_reads_one: assert property (updRd |=> rdData[0])
    else $error("update strobe not read back");
  a_update_clears: assert property (quietRd |=> !rdData[0])
    else $error("update strobe did not clear");
  a_unmapped_zero: assert property (
    rdAddr == 16'h0300 |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_status_lock: assert property (
    rdAddr == 16'h0201 && $past(rst_n) && $stable(loopLocked)
    |=> rdData[0] == $past(loopLocked))
    else $error("lock status wrong");
  a_status_cal: assert property (
    calDone ##1 calDone && rdAddr == 16'h0201 |=> rdData[1])
    else $error("calibration status wrong");
  a_group_off_pins: assert property (
    groupDividerDown[1] [*3] |-> outputPositivePin[4:2] == 3'h0
    && outputNegativePin[4:2] == 3'h0)
    else $error("powered group still drives");
  a_reset_groups: assert property (
    $rose(rst_n) |-> groupDividerDown == 4'hF)
    else $error("groups not down after reset");
  a_cal_on_update: assert property (
    $changed(manualCalibrate) |-> $past(updW, 3))
    else $error("setting changed without update");
endmodule : pod_distribution_chk
bind pod_distribution pod_distribution_chk #(
  .DRIVERS(DRIVERS), .GROUPS(GROUPS)) pod_distribution_chk_i (
  .core_clk, .rst_n, .regWrite, .rdAddr, .rdData, .loopLocked,
  .calDone, .outputPositivePin, .outputNegativePin,
  .groupDividerDown, .manualCalibrate);

// File: testbench/pod_distribution_test.sv
`timescale 1ns/100ps
module pod_distribution_test;
  import pod_pkg::*;
  logic          core_clk = 1'b0;
  logic          rst_n = 1'b0;
  pod_write_type regWrite = '0;
  logic [15:0]   rdAddr = 16'h0000;
  logic          lockEn = 1'b0;
  logic          calEn = 1'b0;
  logic          tick, locked, calOk, manCal;
  logic [7:0]    rdData;
  logic [11:0]   outP, outN;
  logic [3:0]    grpDown;
  int            n_mismatch = 0;
  int            comparisons = 0;
  int            hi = 0;
  pod_loop_model pod_loop_model_i (.core_clk(core_clk), .lockEn(lockEn),
    .calEn(calEn), .tick(tick), .locked(locked), .calOk(calOk));
  pod_distribution pod_distribution_i (.core_clk(core_clk), .rst_n(rst_n),
    .regWrite(regWrite), .rdAddr(rdAddr), .vcoPostDividerTick(tick),
    .loopLocked(locked), .calDone(calOk), .rdData(rdData),
    .outputPositivePin(outP), .outputNegativePin(outN),
    .groupDividerDown(grpDown), .manualCalibrate(manCal));
  initial forever #2.5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task cmp(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [15:0] a, input logic [7:0] d);
    step(1);
    regWrite = '{1'b1, a, d};
    step(1);
    regWrite.wrEn = 1'b0;
  endtask : wr
  // Active copies load one edge after the strobe, pins one later
  task upd;
    wr(16'h0005, 8'h01);
    step(6);
  endtask : upd
  task rd(input logic [15:0] a, input logic [7:0] e);
    step(1);
    rdAddr = a;
    step(1);
    cmp({4'h0, rdData}, {4'h0, e});
  endtask : rd
  // Cycles between two rising edges of a positive pin
  task per(input int i, input int e);
    int k; int r; int t0; logic pv;
    r = 0;
    t0 = 0;
    pv = outP[i];
    for (k = 0; k < 1200 && r < 2; k++) begin
      step(1);
      if (!pv && outP[i]) begin
        if (r == 1) cmp(12'(k - t0), 12'(e));
        t0 = k;
        r++;
      end
      pv = outP[i];
    end
    if (r < 2) cmp(12'hFFF, 12'(e));
  endtask : per
  function automatic logic expP(input int m, input int p, input logic r);
    case (m)
      1: return r;
      4, 5: return p[1] ? ~r : r;
      default: return 1'b0;
    endcase
  endfunction : expP
  function automatic logic expN(input int m, input int p, input logic r);
    case (m)
      1: return ~r;
      4, 6: return p[0] ? r : ~r;
      default: return 1'b0;
    endcase
  endfunction : expN
  task complete_run;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    step(8);
    rst_n = 1'b1;
    cmp({8'h00, grpDown}, 12'h00F);
    rd(16'h0200, 8'h00);
    rd(16'h0300, 8'h00);
    // Driver 1 is the reference: CMOS, both pins normal
    wr(16'h0210, 8'h00);
    wr(16'h0221, 8'h0C);
    for (int m = 0; m < 8; m++) begin
      for (int p = 0; p < 4; p++) begin
        wr(16'h0220, 8'((p << 3) | m));
        upd;
        repeat (3) begin
          cmp({10'h0, outP[0], outN[0]}, {10'h0, expP(m, p, outP[1]),
              expN(m, p, outP[1])});
          step(1);
        end
      end
    end
    cmp({8'h00, grpDown}, 12'h00E);
    wr(16'h0220, 8'h0C);
    wr(16'h0221, 8'h2C);
    rd(16'h0221, 8'h2C);
    upd;
    cmp({10'h0, outP[1], outN[1]}, 12'h000);
    per(0, 2);
    wr(16'h0210, 8'hFF);
    step(6);
    per(0, 2);
    upd;
    per(0, 512);
    wr(16'h0210, 8'h02);
    wr(16'h0220, 8'h20);
    upd;
    cmp({8'h00, grpDown}, 12'h00F);
    wr(16'h0200, 8'h02);
    step(3);
    cmp({11'h0, manCal}, 12'h000);
    upd;
    cmp({11'h0, manCal}, 12'h001);
    // Groups A and B at ratio 2, synced while the loop is unlocked
    wr(16'h0211, 8'h02);
    wr(16'h0221, 8'h0C);
    wr(16'h0222, 8'h0C);
    rdAddr = 16'h0005;
    wr(16'h0200, 8'h04);
    upd;
    repeat (8) begin
      cmp({10'h0, outP[2:1]}, 12'h000);
      step(1);
    end
    wr(16'h0200, 8'h00);
    upd;
    lockEn = 1'b1;
    repeat (12) begin
      cmp({10'h0, outP[2:1]}, 12'h000);
      step(1);
    end
    rd(16'h0201, 8'h0D);
    calEn = 1'b1;
    step(6);
    repeat (12) begin
      cmp({11'h0, outP[1]}, {11'h0, outP[2]});
      step(1);
    end
    per(1, 6);
    hi = 0;
    repeat (6) begin
      step(1);
      hi += outP[1];
    end
    cmp(12'(hi), 12'h004);
    // Qualified sync: hold drops as soon as the bit falls
    wr(16'h0200, 8'h04);
    upd;
    cmp({10'h0, outP[2:1]}, 12'h000);
    rd(16'h0201, 8'h0B);
    wr(16'h0200, 8'h00);
    upd;
    rd(16'h0201, 8'h03);
    repeat (6) begin
      cmp({11'h0, outP[1]}, {11'h0, outP[2]});
      step(1);
    end
    per(2, 6);
    complete_run;
  end
endmodule : pod_distribution_test
